// >>> core/sbm_loader.sv
// Two-wire serial-bus master with reset-time EEPROM loader
`timescale 1ns/10ps
`default_nettype none
module sbm_loader import sbm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire sbm_cfg_req_t cfg_req,
	output logic [7:0] cfg_rdata,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output sbm_ld_t ld_out,
	output logic ld_done,
	output logic busy
);
	// ------------------------------------------------------------
	// Operation sequences
	// ------------------------------------------------------------
	// write, read, quick and load step tables
	function automatic sbm_op_t op_at(input sbm_mode_t mode, input logic [3:0] step);
		sbm_op_t op;
		op = OP_END;
		unique case (mode)
			M_WR: begin
				unique case (step)
					4'h0: op = OP_S;
					4'h1: op = OP_AW;
					4'h2: op = OP_IX;
					4'h3: op = OP_DT;
					4'h4: op = OP_P;
					default: op = OP_END;
				endcase
			end
			M_QK: begin
				unique case (step)
					4'h0: op = OP_S;
					4'h1: op = OP_AQ;
					4'h2: op = OP_P;
					default: op = OP_END;
				endcase
			end
			default: begin
				unique case (step)
					4'h0, 4'h3: op = OP_S;
					4'h1: op = OP_AW;
					4'h2: op = OP_IX;
					4'h4: op = OP_AR;
					4'h5: op = OP_RX;
					4'h6: op = (mode == M_LD) ? OP_RX : OP_P;
					4'h7, 4'h8: op = (mode == M_LD) ? OP_RX : OP_END;
					4'h9: op = (mode == M_LD) ? OP_P : OP_END;
					default: op = OP_END;
				endcase
			end
		endcase
		return op;
	endfunction

	// Step of the stop condition, used when a transfer aborts
	function automatic logic [3:0] stop_at(input sbm_mode_t mode);
		logic [3:0] s;
		unique case (mode)
			M_WR: s = 4'h4;
			M_RD: s = 4'h6;
			M_QK: s = 4'h2;
			default: s = 4'h9;
		endcase
		return s;
	endfunction

	// Pin releases {scl, sda} for an operation phase
	function automatic logic [1:0] pin_drive(input sbm_op_t op, input logic [1:0] ph, input logic [3:0] bitn,
			input logic [7:0] sh, input logic sda_prev);
		logic scl_rel;
		logic sda_rel;
		scl_rel = ph[1];
		sda_rel = 1'b1;
		unique case (op)
			// SDA falls in the last high quarter
			OP_S: sda_rel = (ph != 2'h3);
			// SDA rises in the last high quarter
			OP_P: sda_rel = (ph == 2'h3);
			OP_RX: sda_rel = (bitn != SBM_ACK_BIT);
			OP_END: scl_rel = 1'b1;
			default: sda_rel = (bitn == SBM_ACK_BIT) | sh[7];
		endcase
		// Outside start and stop, SDA only moves once SCL is already low
		if (ph == 2'h0 && op != OP_END) begin
			sda_rel = sda_prev;
		end
		return {scl_rel, sda_rel};
	endfunction

	// ------------------------------------------------------------
	// Pin synchroniser and bit timer
	// ------------------------------------------------------------
	sbm_core_t r_q;
	sbm_core_t r_d;
	logic [1:0] pin_lvl;
	logic scl_s;
	logic sda_s;
	logic tick;
	sbm_op_t cur_op;
	logic is_tx;
	logic wr_tadr;
	logic [1:0] drv;

	sbm_pin_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_raw({scl_in, sda_in}),
		.pin_lvl(pin_lvl)
	);

	sbm_qtr_div u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(r_q.st == ST_RUN),
		.tick(tick)
	);

	assign scl_s = pin_lvl[1];
	assign sda_s = pin_lvl[0];
	assign cur_op = op_at(r_q.mode, r_q.step);
	assign is_tx = (cur_op == OP_AW) || (cur_op == OP_AR) || (cur_op == OP_AQ) ||
		(cur_op == OP_IX) || (cur_op == OP_DT);
	assign wr_tadr = cfg_req.wr && (cfg_req.addr == SBM_OFS_TADR);
	assign drv = pin_drive(cur_op, r_q.ph, r_q.bitn, r_q.sh, r_q.sda_oe_n);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [3:0] nstep;
		sbm_op_t nop;
		logic [6:0] a7;
		nstep = 4'h0;
		nop = OP_END;
		a7 = (r_q.mode == M_LD) ? SBM_EEPROM_ADDR : r_q.tadr[7:1];
		r_d = r_q;
		r_d.ld.valid = 1'b0;

		// Software writes come first so hardware sets win
		if (cfg_req.wr) begin
			unique case (cfg_req.addr)
				SBM_OFS_DATA: r_d.data = cfg_req.wdata;
				SBM_OFS_IDX: r_d.idx = cfg_req.wdata;
				SBM_OFS_CTL: begin
					r_d.quick = cfg_req.wdata[SBM_CTL_QUICK];
					if (cfg_req.wdata[SBM_CTL_ERR]) begin
						r_d.err = 1'b0;
					end
				end
				default: ;
			endcase
		end

		unique case (r_q.st)
			// wait for the synchroniser, then look for the pullup
			ST_BOOT: begin
				if (r_q.wait_n != SBM_BOOT_WAIT) begin
					r_d.wait_n = r_q.wait_n + 3'h1;
				end else if (scl_s) begin
					r_d.st = ST_RUN;
					r_d.mode = M_LD;
					r_d.busy = 1'b1;
					r_d.step = 4'h0;
				end else begin
					r_d.st = ST_IDLE;
					r_d.ld_done = 1'b1;
				end
			end
			ST_IDLE: begin
				if (wr_tadr && !r_q.busy) begin
					r_d.tadr = cfg_req.wdata;
					r_d.mode = r_q.quick ? M_QK : (cfg_req.wdata[SBM_TADR_RW] ? M_RD : M_WR);
					r_d.st = ST_RUN;
					r_d.busy = 1'b1;
					r_d.rdv = 1'b0;
					r_d.step = 4'h0;
					r_d.ph = 2'h0;
					r_d.bitn = 4'h0;
					r_d.abort = 1'b0;
				end
			end
			default: begin
				// writes to the slave address are ignored here
				if (cur_op == OP_END) begin
					// only the loader repeats doubleword reads
					if (r_q.mode == M_LD && !r_q.abort &&
							({1'b0, r_q.ptr} + SBM_DWORD < {1'b0, r_q.cnt} + SBM_HDR_BYTES)) begin
						r_d.ptr = r_q.ptr + SBM_DWORD[7:0];
						r_d.step = 4'h0;
						r_d.ph = 2'h0;
						r_d.bitn = 4'h0;
					end else begin
						r_d.st = ST_IDLE;
						r_d.busy = 1'b0;
						r_d.abort = 1'b0;
						if (r_q.mode == M_LD) begin
							r_d.ld_done = 1'b1;
						end
					end
				end else if (tick) begin
					r_d.ph = r_q.ph + 2'h1;
					if (r_q.ph == 2'h2) begin
						if (is_tx && r_q.bitn == SBM_ACK_BIT && sda_s) begin
							r_d.err = 1'b1;
							r_d.abort = 1'b1;
						end
						if (cur_op == OP_RX && r_q.bitn != SBM_ACK_BIT) begin
							r_d.sh = {r_q.sh[6:0], sda_s};
						end
					end
					if (r_q.ph == 2'h3) begin
						// eight data bits then the acknowledge
						if ((is_tx || cur_op == OP_RX) && r_q.bitn != SBM_ACK_BIT) begin
							r_d.bitn = r_q.bitn + 4'h1;
							if (is_tx) begin
								r_d.sh = {r_q.sh[6:0], 1'b0};
							end
						end else begin
							r_d.bitn = 4'h0;
							nstep = (r_q.abort && cur_op != OP_P) ? stop_at(r_q.mode) : r_q.step + 4'h1;
							nop = op_at(r_q.mode, nstep);
							r_d.step = nstep;
							// byte loaded for the next operation
							unique case (nop)
								OP_AW: r_d.sh = {a7, 1'b0};
								OP_AR: r_d.sh = {a7, 1'b1};
								OP_AQ: r_d.sh = r_q.tadr;
								OP_IX: r_d.sh = (r_q.mode == M_LD) ? r_q.ptr : r_q.idx;
								OP_DT: r_d.sh = r_q.data;
								default: ;
							endcase
							// received byte is kept or handed on
							if (cur_op == OP_RX && r_q.mode == M_RD) begin
								r_d.data = r_q.sh;
								r_d.rdv = 1'b1;
							end
							if (cur_op == OP_RX && r_q.mode == M_LD) begin
								r_d.ld.valid = 1'b1;
								r_d.ld.data = r_q.sh;
								r_d.ld.offset = r_q.ptr + {6'h00, 2'(r_q.step - SBM_LD_RX0)};
								// byte count comes from image offset one
								if (r_q.ptr + {6'h00, 2'(r_q.step - SBM_LD_RX0)} == SBM_CNT_OFS) begin
									r_d.cnt = r_q.sh;
								end
							end
						end
					end
				end
			end
		endcase

		// both lines released outside a running transfer
		if (r_q.st == ST_RUN) begin
			r_d.scl_oe_n = drv[1];
			r_d.sda_oe_n = drv[0];
		end else begin
			r_d.scl_oe_n = 1'b1;
			r_d.sda_oe_n = 1'b1;
		end

		unique case (cfg_req.addr)
			SBM_OFS_DATA: r_d.rdata = r_q.data;
			SBM_OFS_IDX: r_d.rdata = r_q.idx;
			SBM_OFS_TADR: r_d.rdata = r_q.tadr;
			SBM_OFS_CTL: begin
				r_d.rdata = 8'h00;
				r_d.rdata[SBM_CTL_QUICK] = r_q.quick;
				r_d.rdata[SBM_CTL_ERR] = r_q.err;
				r_d.rdata[SBM_CTL_RDV] = r_q.rdv;
				r_d.rdata[SBM_CTL_BUSY] = r_q.busy;
			end
			default: r_d.rdata = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= '{st: ST_BOOT, mode: M_WR, scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	assign cfg_rdata = r_q.rdata;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = r_q.scl_oe_n;
	assign sda_oe_n = r_q.sda_oe_n;
	assign ld_out = r_q.ld;
	assign ld_done = r_q.ld_done;
	assign busy = r_q.busy;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_launch;
		@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == ST_IDLE && !r_q.busy && wr_tadr) |=> (busy && r_q.st == ST_RUN && r_q.step == 4'h0);
	endproperty
	a_launch: assert property (p_launch) else $error("Address write did not launch");

	property p_no_relaunch;
		@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == ST_RUN && wr_tadr && cur_op != OP_END && !tick) |=> ($stable(r_q.step) && $stable(r_q.tadr));
	endproperty
	a_no_relaunch: assert property (p_no_relaunch) else $error("Busy write restarted transfer");

	property p_sda_stable;
		@(posedge clk_sys) disable iff (!rst_n)
		(scl_oe_n && $past(scl_oe_n) && (is_tx || cur_op == OP_RX) && $past(r_q.st) == ST_RUN) |-> $stable(sda_oe_n);
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("SDA moved while SCL high");

	property p_start;
		@(posedge clk_sys) disable iff (!rst_n)
		($fell(sda_oe_n) && $past(cur_op) == OP_S) |-> scl_oe_n;
	endproperty
	a_start: assert property (p_start) else $error("Start without SCL high");

	property p_stop;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(sda_oe_n) && $past(cur_op) == OP_P) |-> scl_oe_n;
	endproperty
	a_stop: assert property (p_stop) else $error("SDA rose while SCL low");

	property p_idle_release;
		@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == ST_IDLE && !wr_tadr) |=> (scl_oe_n && sda_oe_n) [*2];
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("Pins driven while idle");

	property p_nack_err;
		@(posedge clk_sys) disable iff (!rst_n)
		(tick && r_q.ph == 2'h2 && is_tx && r_q.bitn == SBM_ACK_BIT && sda_s) |=> (r_q.err && r_q.abort);
	endproperty
	a_nack_err: assert property (p_nack_err) else $error("Missing ack not flagged");

	property p_quick_no_idx;
		@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == ST_RUN && r_q.mode == M_QK) |-> (cur_op != OP_IX && cur_op != OP_DT);
	endproperty
	a_quick_no_idx: assert property (p_quick_no_idx) else $error("Quick command sent index");

	property p_ld_addr;
		@(posedge clk_sys) disable iff (!rst_n)
		(r_q.mode == M_LD && (cur_op == OP_AW || cur_op == OP_AR) && r_q.bitn == 4'h0 && r_q.ph == 2'h0)
			|-> (r_q.sh[7:1] == 7'h50);
	endproperty
	a_ld_addr: assert property (p_ld_addr) else $error("Loader used wrong address");

	property p_ld_only_boot;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(r_q.mode == M_LD) && r_q.st == ST_RUN) |-> ($past(r_q.st) == ST_BOOT);
	endproperty
	a_ld_only_boot: assert property (p_ld_only_boot) else $error("Load started outside reset");
endmodule
`default_nettype wire

// >>> core/sbm_pkg.sv
// Shared constants, types and state records of the serial-bus master and loader
package sbm_pkg;

	// ------------------------------------------------------------
	// Register offsets and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] SBM_OFS_DATA = 8'hb0;
	localparam logic [7:0] SBM_OFS_IDX = 8'hb1;
	localparam logic [7:0] SBM_OFS_TADR = 8'hb2;
	localparam logic [7:0] SBM_OFS_CTL = 8'hb3;
	localparam int SBM_CTL_QUICK = 0;
	localparam int SBM_CTL_ERR = 1;
	localparam int SBM_CTL_RDV = 3;
	localparam int SBM_CTL_BUSY = 5;
	localparam int SBM_TADR_RW = 0;

	// ------------------------------------------------------------
	// Loader constants
	// ------------------------------------------------------------
	localparam logic [6:0] SBM_EEPROM_ADDR = 7'h50;
	localparam logic [7:0] SBM_CNT_OFS = 8'h01;
	localparam logic [8:0] SBM_HDR_BYTES = 9'h002;
	localparam logic [8:0] SBM_DWORD = 9'h004;
	localparam logic [3:0] SBM_LD_RX0 = 4'h5;
	localparam logic [3:0] SBM_ACK_BIT = 4'h8;
	localparam logic [2:0] SBM_BOOT_WAIT = 3'h7;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SBM_CLK_PERIOD_NS = 10;
	localparam int SBM_SCL_PERIOD_NS = 10000;
	// Quarter of an SCL period, rounded up so SCL never runs fast
	localparam int SBM_QTR_CYC = (SBM_SCL_PERIOD_NS + 4 * SBM_CLK_PERIOD_NS - 1) / (4 * SBM_CLK_PERIOD_NS);
	localparam logic [7:0] SBM_QTR_LAST = 8'(SBM_QTR_CYC - 1);

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BOOT = 3'b010,
		ST_RUN = 3'b100
	} sbm_st_t;

	typedef enum logic [1:0] {
		M_WR = 2'h0,
		M_RD = 2'h1,
		M_QK = 2'h2,
		M_LD = 2'h3
	} sbm_mode_t;

	typedef enum logic [3:0] {
		OP_S = 4'h0,
		OP_AW = 4'h1,
		OP_AR = 4'h2,
		OP_AQ = 4'h3,
		OP_IX = 4'h4,
		OP_DT = 4'h5,
		OP_RX = 4'h6,
		OP_P = 4'h7,
		OP_END = 4'h8
	} sbm_op_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sbm_cfg_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] offset;
		logic [7:0] data;
	} sbm_ld_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] lvl;
	} sbm_sync_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} sbm_div_t;

	typedef struct packed {
		sbm_st_t st;
		sbm_mode_t mode;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [3:0] step;
		logic abort;
		logic [7:0] sh;
		logic [7:0] data;
		logic [7:0] idx;
		logic [7:0] tadr;
		logic quick;
		logic err;
		logic rdv;
		logic busy;
		logic scl_oe_n;
		logic sda_oe_n;
		logic [7:0] rdata;
		logic [2:0] wait_n;
		logic [7:0] ptr;
		logic [7:0] cnt;
		sbm_ld_t ld;
		logic ld_done;
	} sbm_core_t;

endpackage

// >>> core/sbm_pin_sync.sv
// Three-stage synchroniser for the SCL and SDA pin inputs
`timescale 1ns/10ps
`default_nettype none
module sbm_pin_sync import sbm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] pin_raw,
	output logic [1:0] pin_lvl
);
	sbm_sync_t r_q;
	sbm_sync_t r_d;

	// ------------------------------------------------------------
	// Level follows only when the second and third stages agree
	// ------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.s1 = pin_raw;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		for (int i = 0; i < 2; i++) begin
			if (r_q.s2[i] == r_q.s3[i]) begin
				r_d.lvl[i] = r_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, lvl: 2'h3};
		end else begin
			r_q <= r_d;
		end
	end

	assign pin_lvl = r_q.lvl;
endmodule
`default_nettype wire

// >>> core/sbm_qtr_div.sv
// Quarter-bit tick generator for the SCL timing
`timescale 1ns/10ps
`default_nettype none
module sbm_qtr_div import sbm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic run,
	output logic tick
);
	sbm_div_t r_q;
	sbm_div_t r_d;

	// ------------------------------------------------------------
	// Counter restarts whenever the engine is not running
	// ------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.tick = 1'b0;
		if (!run) begin
			r_d.cnt = 8'h00;
		end else if (r_q.cnt == SBM_QTR_LAST) begin
			r_d.cnt = 8'h00;
			r_d.tick = 1'b1;
		end else begin
			r_d.cnt = r_q.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= '{cnt: 8'h00, tick: 1'b0};
		end else begin
			r_q <= r_d;
		end
	end

	assign tick = r_q.tick;

	// quarter ticks never closer than eight
	property p_tick_space;
		@(posedge clk_sys) disable iff (!rst_n)
		tick |=> !tick [*8];
	endproperty
	a_tick_space: assert property (p_tick_space) else $error("Quarter ticks too close");
endmodule
`default_nettype wire

// >>> tb/sbm_eeprom_model.sv
// Behavioural serial EEPROM slave on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module sbm_eeprom_model #(
	parameter logic [6:0] DEV_ADDR = 7'h50,
	parameter logic [7:0] IMG_COUNT = 8'h20
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_pull
);
	logic [7:0] mem [256];
	logic [7:0] ptr;
	logic rs;

	// ------------------------------------------------------------
	// Image
	// ------------------------------------------------------------
	// indicator and count
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'ha5;
		end
		mem[0] = 8'h00;
		mem[1] = IMG_COUNT;
	end

	// ------------------------------------------------------------
	// Bit level
	// ------------------------------------------------------------
	task automatic get_byte(output logic [7:0] b);
		repeat (8) begin
			@(posedge scl);
			b = {b[6:0], sda};
		end
	endtask

	task automatic ack();
		@(negedge scl);
		sda_pull = 1'b1;
		@(negedge scl);
		sda_pull = 1'b0;
	endtask

	// read bits change while SCL low
	task automatic send_byte(input logic [7:0] b, output logic more);
		for (int i = 7; i >= 0; i--) begin
			sda_pull = ~b[i];
			@(negedge scl);
		end
		sda_pull = 1'b0;
		@(posedge scl);
		more = ~sda;
		@(negedge scl);
	endtask

	// ------------------------------------------------------------
	// Frame
	// ------------------------------------------------------------
	// Keeps sending after a master ack, like a real part; a stop only lands when the next MSB is 1
	task automatic frame();
		logic [7:0] b;
		logic more;
		get_byte(b);
		if (b[7:1] != DEV_ADDR) return;
		ack();
		if (b[0]) begin
			more = 1'b1;
			while (more) begin
				send_byte(mem[ptr], more);
				ptr++;
			end
		end else begin
			get_byte(b);
			ptr = b;
			ack();
			forever begin
				get_byte(b);
				mem[ptr] = b;
				ptr++;
				ack();
			end
		end
	endtask

	initial begin
		sda_pull = 1'b0;
		ptr = 8'h00;
		rs = 1'b0;
		forever begin
			if (!rs) @(negedge sda iff scl === 1'b1);
			rs = 1'b0;
			fork
				frame();
				@(posedge sda iff scl === 1'b1);
				begin
					@(negedge sda iff scl === 1'b1);
					rs = 1'b1;
				end
			join_any
			disable fork;
			sda_pull = 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the serial-bus master and reset-time loader
`timescale 1ns/10ps
`default_nettype none
module tb_top import sbm_pkg::*; ;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} sbm_row_t;

	logic clk_sys, rst_n, scl_gnd, scl_oe_n, sda_oe_n, ld_done, busy, ee_pull;
	sbm_cfg_req_t cfg_req;
	logic [7:0] cfg_rdata;
	sbm_ld_t ld_out;
	wire logic scl;
	wire logic sda;
	int miscompares, compares, ld_cnt;
	time last_fall;
	sbm_row_t rows [5] = '{'{8'hb0, 8'ha5, 8'ha5}, '{8'hb1, 8'h5a, 8'h5a}, '{8'hb3, 8'h01, 8'h01},
		'{8'hb3, 8'hfe, 8'h00}, '{8'hc4, 8'hff, 8'h00}};

	// Open-drain wires with pull-ups; SCL can be grounded to hide the pull-up
	assign scl = (!scl_oe_n || scl_gnd) ? 1'b0 : 1'b1;
	assign sda = (!sda_oe_n || ee_pull) ? 1'b0 : 1'b1;

	sbm_loader dut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .scl_in(scl),
		.scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n), .ld_out(ld_out),
		.ld_done(ld_done), .busy(busy));
	// Short image keeps the load to one doubleword
	sbm_eeprom_model #(.IMG_COUNT(8'h02)) u_ee (.scl(scl), .sda(sda), .sda_pull(ee_pull));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		cfg_req = '{wr: 1'b1, addr: a, wdata: d};
		@(negedge clk_sys);
		cfg_req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
		@(negedge clk_sys);
		cfg_req = '{wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clk_sys);
		check(cfg_rdata, e, what);
	endtask

	task automatic wait_idle(input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(negedge clk_sys);
			if (busy === 1'b0) break;
		end
		if (i == lim) begin
			miscompares++;
			wrap_up();
		end
	endtask

	function automatic logic [7:0] img(input logic [7:0] a);
		return (a == 8'h00) ? 8'h00 : (a == 8'h01) ? 8'h02 : a ^ 8'ha5;
	endfunction

	// ------------------------------------------------------------
	// Monitors
	// ------------------------------------------------------------
	always @(negedge clk_sys) begin
		if (ld_out.valid === 1'b1) begin
			check(ld_out.offset, 8'(ld_cnt), "ld_offset");
			check(ld_out.data, img(8'(ld_cnt)), "ld_data");
			ld_cnt++;
		end
	end

	always @(negedge scl) last_fall = $time;
	always @(posedge scl) begin
		if (last_fall > 0) check(8'($time - last_fall >= 5000), 8'h01, "scl_low_time");
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		scl_gnd = 1'b0;
		cfg_req = '0;
		miscompares = 0;
		compares = 0;
		ld_cnt = 0;
		last_fall = 0;
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (14) @(negedge clk_sys);
		check(busy, 8'h01, "busy_load");
		wait_idle(100000);
		check(ld_done, 8'h01, "ld_done");
		check(8'(ld_cnt), 8'h04, "ld_count");

		wr(SBM_OFS_IDX, 8'h10);
		wr(SBM_OFS_DATA, 8'h3c);
		wr(SBM_OFS_CTL, 8'h02);
		wr(SBM_OFS_TADR, 8'ha0);
		wr(SBM_OFS_TADR, 8'h66);
		rd(SBM_OFS_CTL, 8'h20, "ctl_busy");
		wait_idle(40000);
		check(u_ee.mem[16], 8'h3c, "ee_write");
		rd(SBM_OFS_TADR, 8'ha0, "tadr_kept");

		wr(SBM_OFS_TADR, 8'ha1);
		wait_idle(60000);
		rd(SBM_OFS_DATA, 8'h3c, "read_data");
		rd(SBM_OFS_CTL, 8'h08, "read_valid");

		wr(SBM_OFS_CTL, 8'h01);
		wr(SBM_OFS_TADR, 8'h67);
		wait_idle(20000);
		rd(SBM_OFS_CTL, 8'h03, "nack_error");
		wr(SBM_OFS_CTL, 8'h02);
		rd(SBM_OFS_CTL, 8'h00, "error_clear");

		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].exp, "reg_readback");
		end

		scl_gnd = 1'b1;
		rst_n = 1'b0;
		ld_cnt = 0;
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (14) @(negedge clk_sys);
		check(ld_done, 8'h01, "skip_done");
		check(busy, 8'h00, "skip_busy");
		check(8'(ld_cnt), 8'h00, "skip_count");
		wrap_up();
	end
endmodule
`default_nettype wire
